// ===== logic/abd_detector.v
// Purpose: per-frame audio bandwidth detector with an Avalon-MM register slave
// Assumes: bins, frame_end, activity and noise level come from logic on clk
// Notes: bins arriving while busy is high are dropped
//
// Behaviour
// - detection runs only when the input rate is above 8 kHz.
// - result is one of narrow, wide, super wide or full band.
// - each aggregated band sums four consecutive 400 Hz bins.
// - nine bands with fixed bin ranges 3-6 through 46-49.
// - log10 of band energy divided by eight times rate scale squared.
// - class means from band groups, each plus 1.6.
// - class maxima from band group maxima plus 1.6; narrow uses its mean plus 1.6.
// - legacy mode takes DCT band energies instead of filterbank ones.
// - DCT variant uses windowed 320 sample transform split in nine bands.
// - DCT variant takes plain log10 and drops the 1.6 offset.
// - same decision logic for both variants, only thresholds differ.
// - long-term means move by 0.75 old plus 0.25 current.
// - long-term update only when active and noise above 30 dB.
// - class counters step up or down by ordered threshold tests.
// - sequential counter tests pick bandwidth and force counters to 0 or 100.
// - at 9.6 kbps a full band result becomes super wide band.
// - each class only inside its bitrate range, otherwise lowered; narrow band above its range is raised.
`timescale 1ns/10ps
`include "abd_consts.vh"
module abd_detector (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire bin_valid,
  input wire [5:0] bin_index,
  input wire [31:0] bin_energy,
  input wire frame_end,
  input wire activity_decision,
  input wire signed [15:0] noise_level,
  output reg [1:0] selected_bandwidth,
  output reg bw_valid,
  output reg busy
);
  localparam S_IDLE = 3'h0;
  localparam S_LOG = 3'h1;
  localparam S_LT = 3'h2;
  localparam S_CNT = 3'h3;
  localparam S_SEL = 3'h4;
  localparam S_OUT = 3'h5;

  reg [2:0] state_r;
  reg [3:0] ctrl_r;
  reg [15:0] bitrate_r;
  reg [3:0] log_idx_r;
  reg signed [15:0] loge_r [0:8];
  reg signed [15:0] lt_nb_r;
  reg signed [15:0] lt_wb_r;
  reg signed [15:0] lt_swb_r;
  reg [1:0] bw_r;
  reg clear_r;

  wire en = ctrl_r[`ABD_CTRL_EN_BIT];
  wire legacy_interop_mode = ctrl_r[`ABD_CTRL_LEGACY_BIT];
  wire [1:0] rate = ctrl_r[`ABD_CTRL_RATE_LSB+1:`ABD_CTRL_RATE_LSB];
  wire req = avs_read | avs_write;
  wire take = req & ~avs_waitrequest;

  function [5:0] band_start;
    input [3:0] b;
    begin
      case (b)
        4'h0: band_start = `ABD_B0_START;
        4'h1: band_start = `ABD_B1_START;
        4'h2: band_start = `ABD_B2_START;
        4'h3: band_start = `ABD_B3_START;
        4'h4: band_start = `ABD_B4_START;
        4'h5: band_start = `ABD_B5_START;
        4'h6: band_start = `ABD_B6_START;
        4'h7: band_start = `ABD_B7_START;
        default: band_start = `ABD_B8_START;
      endcase
    end
  endfunction

  function signed [15:0] smax;
    input signed [15:0] a;
    input signed [15:0] b;
    begin
      smax = (a > b) ? a : b;
    end
  endfunction

  // per-band accumulators; bin 14 feeds two bands, hence parallel adders
  wire [35:0] band_sum [0:8];
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : g_band
      reg [35:0] acc_r;
      wire [5:0] lo = band_start(g[3:0]);
      wire hit = (bin_index >= lo) && (bin_index < lo + `ABD_BINS_PER_BAND);
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          acc_r <= 36'h000000000;
        end else if (ce) begin
          if (clear_r) begin
            acc_r <= 36'h000000000;
          end else if (state_r == S_IDLE && bin_valid && hit) begin
            acc_r <= acc_r + {4'h0, bin_energy};
          end
        end
      end
      assign band_sum[g] = acc_r;
    end
  endgenerate

  // one band through the log converter per cycle keeps the area to one converter
  wire signed [15:0] log_raw;
  abd_log10 u_log (
    .energy(band_sum[log_idx_r]),
    .log_q88(log_raw)
  );
  reg signed [15:0] scl;
  always @* begin
    case (rate)
      `ABD_RATE_8K: scl = `ABD_SCL_8K;
      `ABD_RATE_16K: scl = `ABD_SCL_16K;
      `ABD_RATE_32K: scl = `ABD_SCL_32K;
      default: scl = `ABD_SCL_48K;
    endcase
  end
  // legacy DCT energies take the plain log, filterbank energies are scaled
  wire signed [15:0] log_band = legacy_interop_mode ? log_raw : log_raw - scl;

  // class means and maxima; the offset vanishes in the DCT variant
  wire signed [15:0] offs = legacy_interop_mode ? 16'sh0000 : `ABD_OFFSET_1P6;
  wire signed [17:0] sum_wb = loge_r[1] + loge_r[2];
  wire signed [17:0] sum_swb = loge_r[3] + loge_r[4] + loge_r[5] + loge_r[6];
  wire signed [17:0] sum_fb = loge_r[7] + loge_r[8];
  wire signed [17:0] sh_wb = sum_wb >>> 1;
  wire signed [17:0] sh_swb = sum_swb >>> 2;
  wire signed [17:0] sh_fb = sum_fb >>> 1;
  wire signed [15:0] mean_nb = loge_r[0] + offs;
  wire signed [15:0] mean_wb = sh_wb[15:0] + offs;
  wire signed [15:0] mean_swb = sh_swb[15:0] + offs;
  wire signed [15:0] max_nb = mean_nb + offs;
  wire signed [15:0] max_wb = smax(loge_r[1], loge_r[2]) + offs;
  wire signed [15:0] max_swb = smax(smax(loge_r[3], loge_r[4]),
                                    smax(loge_r[5], loge_r[6])) + offs;
  wire signed [15:0] max_fb = smax(loge_r[7], loge_r[8]) + offs;
  wire signed [15:0] mean_fb = sh_fb[15:0] + offs;

  // long-term smoothing, 3/4 old plus 1/4 new
  wire signed [17:0] lt_nb_s = ((lt_nb_r * 18'sd3) + mean_nb) >>> 2;
  wire signed [17:0] lt_wb_s = ((lt_wb_r * 18'sd3) + mean_wb) >>> 2;
  wire signed [17:0] lt_swb_s = ((lt_swb_r * 18'sd3) + mean_swb) >>> 2;
  wire lt_upd = activity_decision && (noise_level > `ABD_NOISE_GATE);

  // in the decision logic, thresholds are the only difference between the two variants
  wire signed [15:0] thr_nb = legacy_interop_mode ? `ABD_THR_NB_DCT : `ABD_THR_NB_FLT;
  wire signed [15:0] thr_wb = legacy_interop_mode ? `ABD_THR_WB_DCT : `ABD_THR_WB_FLT;
  wire signed [15:0] thr_swb = legacy_interop_mode ? `ABD_THR_SWB_DCT : `ABD_THR_SWB_FLT;
  wire signed [15:0] thr_fb = legacy_interop_mode ? `ABD_THR_FB_DCT : `ABD_THR_FB_FLT;

  // presence tests, evaluated bottom up: a class only counts if the one below it does
  reg [3:0] cnt_inc;
  reg [3:0] cnt_dec;
  always @* begin
    cnt_inc = 4'h0;
    cnt_dec = 4'h0;
    if (state_r == S_CNT) begin
      if (max_nb > lt_nb_r - thr_nb) cnt_inc[0] = 1'b1;
      else cnt_dec[0] = 1'b1;
      if (cnt_inc[0] && max_wb > lt_nb_r - thr_wb) cnt_inc[1] = 1'b1;
      else cnt_dec[1] = 1'b1;
      if (cnt_inc[1] && max_swb > lt_wb_r - thr_swb) cnt_inc[2] = 1'b1;
      else cnt_dec[2] = 1'b1;
      if (cnt_inc[2] && max_fb > lt_swb_r - thr_fb && mean_fb > lt_swb_r - thr_fb)
        cnt_inc[3] = 1'b1;
      else cnt_dec[3] = 1'b1;
    end
  end

  // counters: 0 narrow, 1 wide, 2 super wide, 3 full
  wire [6:0] cnt [0:3];
  reg [3:0] frc_min;
  reg [3:0] frc_max;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_cnt
      abd_counter u_cnt (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .inc(cnt_inc[g]),
        .dec(cnt_dec[g]),
        .frc_min(frc_min[g]),
        .frc_max(frc_max[g]),
        .cnt_r(cnt[g])
      );
    end
  endgenerate

  // sequential selection; later tests may overturn earlier ones
  reg [1:0] sel;
  always @* begin
    sel = bw_r;
    frc_min = 4'h0;
    frc_max = 4'h0;
    if (state_r == S_SEL) begin
      if (cnt[1] >= `ABD_SEL_UP && sel < `ABD_BW_WB) begin
        sel = `ABD_BW_WB;
        frc_max[0] = 1'b1;
      end
      if (cnt[2] >= `ABD_SEL_UP && sel < `ABD_BW_SWB) begin
        sel = `ABD_BW_SWB;
        frc_max[1:0] = 2'h3;
      end
      if (cnt[3] >= `ABD_SEL_UP) begin
        sel = `ABD_BW_FB;
        frc_max[2:0] = 3'h7;
      end
      if (sel == `ABD_BW_FB && cnt[3] < `ABD_SEL_DN) begin
        sel = `ABD_BW_SWB;
        frc_min[3] = 1'b1;
        frc_max[3] = 1'b0;
      end
      if (sel >= `ABD_BW_SWB && cnt[2] < `ABD_SEL_DN) begin
        sel = `ABD_BW_WB;
        frc_min[3:2] = 2'h3;
        frc_max[3:2] = 2'h0;
      end
      if (sel >= `ABD_BW_WB && cnt[1] < `ABD_SEL_DN) begin
        sel = `ABD_BW_NB;
        frc_min[3:1] = 3'h7;
        frc_max[3:1] = 3'h0;
      end
    end
  end

  // bitrate clamp; narrow band above its range can only be raised to wide band
  reg [1:0] lim;
  always @* begin
    lim = bw_r;
    if (lim == `ABD_BW_FB && bitrate_r < `ABD_RATE_16P4) lim = `ABD_BW_SWB;
    if (lim == `ABD_BW_SWB && bitrate_r < `ABD_RATE_9P6) lim = `ABD_BW_WB;
    if (lim == `ABD_BW_NB && bitrate_r > `ABD_RATE_24P4) lim = `ABD_BW_WB;
  end

  // frame sequencer
  integer i;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= S_IDLE;
      log_idx_r <= 4'h0;
      for (i = 0; i < 9; i = i + 1) loge_r[i] <= 16'sh0000;
      lt_nb_r <= 16'sh0000;
      lt_wb_r <= 16'sh0000;
      lt_swb_r <= 16'sh0000;
      bw_r <= `ABD_BW_NB;
      clear_r <= 1'b0;
      selected_bandwidth <= `ABD_BW_NB;
      bw_valid <= 1'b0;
      busy <= 1'b0;
    end else if (ce) begin
      clear_r <= 1'b0;
      bw_valid <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (frame_end) begin
            if (en && rate != `ABD_RATE_8K) begin
              state_r <= S_LOG;
              busy <= 1'b1;
              log_idx_r <= 4'h0;
            end else begin
              bw_r <= `ABD_BW_NB;
              state_r <= S_OUT;
              busy <= 1'b1;
            end
          end
        end
        S_LOG: begin
          loge_r[log_idx_r] <= log_band;
          log_idx_r <= log_idx_r + 4'h1;
          if (log_idx_r == 4'h8) state_r <= S_LT;
        end
        S_LT: begin
          if (lt_upd) begin
            lt_nb_r <= lt_nb_s[15:0];
            lt_wb_r <= lt_wb_s[15:0];
            lt_swb_r <= lt_swb_s[15:0];
          end
          state_r <= S_CNT;
        end
        S_CNT: state_r <= S_SEL;
        S_SEL: begin
          bw_r <= sel;
          state_r <= S_OUT;
        end
        S_OUT: begin
          selected_bandwidth <= lim;
          bw_valid <= 1'b1;
          busy <= 1'b0;
          clear_r <= 1'b1;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Avalon slave: waitrequest drops one cycle after a request, read data with it
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      ctrl_r <= `ABD_CTRL_RESET;
      bitrate_r <= `ABD_BITRATE_RESET;
    end else if (ce) begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          `ABD_REG_CTRL: avs_readdata <= {28'h0000000, ctrl_r};
          `ABD_REG_BITRATE: avs_readdata <= {16'h0000, bitrate_r};
          `ABD_REG_STATUS: avs_readdata <= {27'h0000000, busy, bw_r, selected_bandwidth};
          `ABD_REG_COUNTERS: avs_readdata <= {4'h0, cnt[3], cnt[2], cnt[1], cnt[0]};
          `ABD_REG_LT_LOW: avs_readdata <= {lt_wb_r, lt_nb_r};
          `ABD_REG_LT_SWB: avs_readdata <= {16'h0000, lt_swb_r};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
      if (take && avs_write) begin
        if (avs_address == `ABD_REG_CTRL && avs_byteenable[0])
          ctrl_r <= avs_writedata[3:0];
        if (avs_address == `ABD_REG_BITRATE) begin
          if (avs_byteenable[0]) bitrate_r[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) bitrate_r[15:8] <= avs_writedata[15:8];
        end
      end
    end
  end
endmodule

// ===== include/abd_consts.vh
// Purpose: constants of the audio bandwidth detector
// Assumes: log energies in signed Q8.8 log10 units, bitrates in units of 100 bit/s
// Notes: definitions only
`ifndef ABD_CONSTS_VH
`define ABD_CONSTS_VH
// register byte offsets
`define ABD_REG_CTRL 5'h00
`define ABD_REG_BITRATE 5'h04
`define ABD_REG_STATUS 5'h08
`define ABD_REG_COUNTERS 5'h0C
`define ABD_REG_LT_LOW 5'h10
`define ABD_REG_LT_SWB 5'h14
// control fields
`define ABD_CTRL_EN_BIT 0
`define ABD_CTRL_LEGACY_BIT 1
`define ABD_CTRL_RATE_LSB 2
`define ABD_CTRL_RESET 4'h0
`define ABD_BITRATE_RESET 16'h0000
// input rate codes
`define ABD_RATE_8K 2'h0
`define ABD_RATE_16K 2'h1
`define ABD_RATE_32K 2'h2
`define ABD_RATE_48K 2'h3
// bandwidth codes
`define ABD_BW_NB 2'h0
`define ABD_BW_WB 2'h1
`define ABD_BW_SWB 2'h2
`define ABD_BW_FB 2'h3
// first bin of each aggregated band, four bins per band
`define ABD_BINS_PER_BAND 6'h04
`define ABD_B0_START 6'h03
`define ABD_B1_START 6'h0B
`define ABD_B2_START 6'h0E
`define ABD_B3_START 6'h17
`define ABD_B4_START 6'h1B
`define ABD_B5_START 6'h1F
`define ABD_B6_START 6'h23
`define ABD_B7_START 6'h2A
`define ABD_B8_START 6'h2E
// log10(8*scl^2) in Q8.8 for scl 88.293854, 88.300926, 88.304118, 88.028412
`define ABD_SCL_8K 16'h04CC
`define ABD_SCL_16K 16'h04CC
`define ABD_SCL_32K 16'h04CC
`define ABD_SCL_48K 16'h04CB
// 1.6 in Q8.8, log10(2) in Q0.8
`define ABD_OFFSET_1P6 16'h019A
`define ABD_LOG10_2 8'h4D
// 30 dB noise gate in Q8.8 dB
`define ABD_NOISE_GATE 16'h1E00
// counter limits
`define ABD_CNT_MIN 7'h00
`define ABD_CNT_MAX 7'h64
`define ABD_CNT_STEP_UP 7'h01
`define ABD_CNT_STEP_DN 7'h01
`define ABD_SEL_UP 7'h5A
`define ABD_SEL_DN 7'h0A
// presence thresholds below a long-term mean (narrow for NB and WB, wide for SWB, super wide for FB), filterbank and DCT variants
`define ABD_THR_NB_FLT 16'h0100
`define ABD_THR_WB_FLT 16'h0300
`define ABD_THR_SWB_FLT 16'h0400
`define ABD_THR_FB_FLT 16'h0500
`define ABD_THR_NB_DCT 16'h0180
`define ABD_THR_WB_DCT 16'h0380
`define ABD_THR_SWB_DCT 16'h0480
`define ABD_THR_FB_DCT 16'h0580
// bitrate limits, 100 bit/s units
`define ABD_RATE_7P2 16'h0048
`define ABD_RATE_9P6 16'h0060
`define ABD_RATE_16P4 16'h00A4
`define ABD_RATE_24P4 16'h00F4
`define ABD_RATE_128 16'h0500
`endif

// ===== logic/abd_log10.v
// Purpose: combinational log10 of an unsigned band energy, Q8.8 result
// Assumes: zero input gives zero
// Notes: piecewise linear mantissa, error below 0.05 in log10
`timescale 1ns/10ps
`include "abd_consts.vh"
module abd_log10 (
  input wire [35:0] energy,
  output reg signed [15:0] log_q88
);
  reg [5:0] msb;
  reg [35:0] norm;
  reg [13:0] log2_q;
  reg [21:0] prod;
  integer k;
  // leading one search; the loop keeps the highest set bit
  always @* begin
    msb = 6'h00;
    norm = 36'h000000000;
    log2_q = 14'h0000;
    prod = 22'h000000;
    for (k = 0; k < 36; k = k + 1) begin
      if (energy[k]) begin
        msb = k[5:0];
      end
    end
    norm = energy << (6'd35 - msb);
    log2_q = {msb, norm[34:27]};
    prod = log2_q * `ABD_LOG10_2;
    log_q88 = (energy == 36'h000000000) ? 16'sh0000 : {2'b00, prod[21:8]};
  end
endmodule

// ===== logic/abd_counter.v
// Purpose: saturating bandwidth counter
// Assumes: force inputs win over steps
// Notes: range held between the count limits at all times
`timescale 1ns/10ps
`include "abd_consts.vh"
module abd_counter (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire inc,
  input wire dec,
  input wire frc_min,
  input wire frc_max,
  output reg [6:0] cnt_r
);
  reg [6:0] cnt_nxt;
  // saturation arithmetic, never leaves the limits
  always @* begin
    cnt_nxt = cnt_r;
    if (frc_min) begin
      cnt_nxt = `ABD_CNT_MIN;
    end else if (frc_max) begin
      cnt_nxt = `ABD_CNT_MAX;
    end else if (inc) begin
      cnt_nxt = (cnt_r >= `ABD_CNT_MAX - `ABD_CNT_STEP_UP) ? `ABD_CNT_MAX :
                cnt_r + `ABD_CNT_STEP_UP;
    end else if (dec) begin
      cnt_nxt = (cnt_r <= `ABD_CNT_MIN + `ABD_CNT_STEP_DN) ? `ABD_CNT_MIN :
                cnt_r - `ABD_CNT_STEP_DN;
    end
  end
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= `ABD_CNT_MIN;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ===== verif/abd_detector_assertions.sv
// Purpose: port checks of the bandwidth detector
// Assumes: one clock domain, reset active low
// Notes: bound into every detector instance
`timescale 1ns/10ps
module abd_detector_chk (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire frame_end,
  input wire [1:0] selected_bandwidth,
  input wire bw_valid,
  input wire busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // a frame end counts only while idle
  sequence frame_taken;
    frame_end && !busy && ce;
  endsequence
  sequence cnt_read;
    avs_read && !avs_waitrequest && (avs_address == 5'h0C);
  endsequence
  // the slave answers one cycle after a request
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("bus request not answered in the next cycle");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  bus_idle_a: assert property (!avs_read && !avs_write |-> avs_waitrequest)
    else $error("waitrequest low without a request");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > 5'h14
    |-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  // every count field stays inside its saturation range
  counter_range_a: assert property (cnt_read |-> avs_readdata[6:0] <= 7'h64 &&
    avs_readdata[13:7] <= 7'h64 && avs_readdata[20:14] <= 7'h64 && avs_readdata[27:21] <= 7'h64)
    else $error("bandwidth counter above its limit");
  frame_result_a: assert property (frame_taken |-> ##[2:14] bw_valid)
    else $error("no result within fourteen cycles of frame end");
  // the bypass path drops busy after one cycle, so only a second busy cycle arms this
  busy_hold_a: assert property (frame_taken ##1 busy ##1 busy |-> busy [*7])
    else $error("busy dropped while the bands were processed");
  valid_pulse_a: assert property (bw_valid |=> !bw_valid)
    else $error("result strobe longer than one cycle");
  bw_hold_a: assert property ($changed(selected_bandwidth) |-> bw_valid)
    else $error("bandwidth changed without result strobe");
  busy_clear_a: assert property (bw_valid |-> !busy)
    else $error("busy still high with the result");
endmodule
bind abd_detector abd_detector_chk chk (.clk, .resetn, .ce, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .frame_end, .selected_bandwidth, .bw_valid, .busy);

// ===== verif/abd_bin_feed.sv
// Purpose: filterbank stage model sending bins 0..49 and a frame end
// Assumes: go is a one-cycle pulse while idle
// Notes: slow mode sends a bin every second cycle
`timescale 1ns/10ps
module abd_bin_feed (
  input wire clk,
  input wire resetn,
  input wire go,
  input wire slow,
  input wire [31:0] level,
  output reg bin_valid,
  output reg [5:0] bin_index,
  output reg [31:0] bin_energy,
  output reg frame_end
);
  reg [6:0] pos_r;
  reg ph_r;
  wire step;
  wire sending;
  assign step = !slow || ph_r;
  assign sending = step && (pos_r < 7'h32);
  // idle lines toggle so a stale value can never pass for data
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pos_r <= 7'h7F;
      ph_r <= 1'b0;
      bin_valid <= 1'b0;
      bin_index <= 6'h00;
      bin_energy <= 32'h00000000;
      frame_end <= 1'b0;
    end else begin
      ph_r <= !ph_r;
      frame_end <= step && (pos_r == 7'h32);
      bin_valid <= sending;
      bin_index <= sending ? pos_r[5:0] : ~bin_index;
      bin_energy <= sending ? level : ~bin_energy;
      if (go) begin
        pos_r <= 7'h00;
      end else if (step && pos_r <= 7'h32) begin
        pos_r <= pos_r + 7'h01;
      end
    end
  end
endmodule

// ===== verif/audio_bandwidth_detector_bench.sv
// Purpose: self-checking bench of the bandwidth detector
// Assumes: ce held high, all lanes enabled
// Notes: fast-path rows run after the full-path frames
`timescale 1ns/10ps
`include "abd_consts.vh"
module audio_bandwidth_detector_bench;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [4:0] avs_address = 5'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h00000000;
  reg activity_decision = 1'b0;
  reg signed [15:0] noise_level = 16'h1F00;
  reg go = 1'b0;
  reg slow = 1'b0;
  reg [31:0] level = 32'h00000000;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire bin_valid;
  wire [5:0] bin_index;
  wire [31:0] bin_energy;
  wire frame_end;
  wire [1:0] selected_bandwidth;
  wire bw_valid;
  wire busy;
  integer num_errors = 0;
  integer n_tests = 0;
  integer i;
  reg [31:0] rd;
  reg [3:0] row_ctrl [0:5];
  reg [15:0] row_rate [0:5];
  reg [1:0] row_bw [0:5];
  always #4 clk = ~clk;
  abd_detector DUT (.clk(clk), .resetn(resetn), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bin_valid(bin_valid), .bin_index(bin_index), .bin_energy(bin_energy),
    .frame_end(frame_end), .activity_decision(activity_decision), .noise_level(noise_level),
    .selected_bandwidth(selected_bandwidth), .bw_valid(bw_valid), .busy(busy));
  abd_bin_feed feed (.clk(clk), .resetn(resetn), .go(go), .slow(slow), .level(level),
    .bin_valid(bin_valid), .bin_index(bin_index), .bin_energy(bin_energy),
    .frame_end(frame_end));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // one bus cycle; request held until waitrequest is sampled low
  task bus(input wr, input [4:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      k = 0;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && k < 50) begin
        @(posedge clk);
        k = k + 1;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (k == 50) begin
        check(32'h0, 32'h1);
        close_out;
      end
    end
  endtask
  // one frame from the feed; latency counted in edges after frame end
  task run_frame(input [31:0] lv, input sl, input [31:0] lat, input [2:0] exp_bw);
    integer k;
    begin
      @(posedge clk);
      level <= lv;
      slow <= sl;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      k = 0;
      while (frame_end !== 1'b1 && k < 200) begin
        @(posedge clk);
        k = k + 1;
      end
      if (k == 200) begin
        check(32'h0, 32'h1);
        close_out;
      end
      k = 0;
      while (bw_valid !== 1'b1 && k < 40) begin
        @(posedge clk);
        #1;
        k = k + 1;
      end
      check(k, lat);
      if (exp_bw[2]) check(selected_bandwidth, exp_bw[1:0]);
    end
  endtask
  initial begin
    // ctrl, bitrate and the clamped result of the fast path
    row_ctrl[0] = 4'h1; row_rate[0] = 16'h00A0; row_bw[0] = `ABD_BW_NB;
    row_ctrl[1] = 4'h1; row_rate[1] = `ABD_RATE_24P4; row_bw[1] = `ABD_BW_NB;
    row_ctrl[2] = 4'h1; row_rate[2] = 16'h00F5; row_bw[2] = `ABD_BW_WB;
    row_ctrl[3] = 4'h4; row_rate[3] = `ABD_RATE_7P2; row_bw[3] = `ABD_BW_NB;
    row_ctrl[4] = 4'h3; row_rate[4] = `ABD_RATE_128; row_bw[4] = `ABD_BW_WB;
    row_ctrl[5] = 4'h0; row_rate[5] = `ABD_RATE_9P6; row_bw[5] = `ABD_BW_NB;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    #1;
    check({busy, bw_valid, selected_bandwidth, avs_waitrequest}, 32'h1);
    bus(1'b0, `ABD_REG_CTRL, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, `ABD_REG_BITRATE, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, `ABD_REG_COUNTERS, 32'hFFFFFFFF);
    bus(1'b0, `ABD_REG_COUNTERS, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 5'h18, 32'hFFFFFFFF);
    bus(1'b0, 5'h18, 32'h0);
    check(rd, 32'h0);
    $display("reset and map test done");
    // full path at 16 kHz: loud frame lifts every counter, silence lowers them
    bus(1'b1, `ABD_REG_CTRL, 32'h5);
    bus(1'b1, `ABD_REG_BITRATE, {16'h0, `ABD_RATE_128});
    run_frame(32'h10000000, 1'b1, 13, 3'h0);
    bus(1'b0, `ABD_REG_COUNTERS, 32'h0);
    check(rd, 32'h00204081);
    bus(1'b0, `ABD_REG_LT_LOW, 32'h0);
    check(rd, 32'h0);
    for (i = 0; i < 2; i = i + 1) begin
      run_frame(32'h0, 1'b0, 13, 3'h0);
      bus(1'b0, `ABD_REG_COUNTERS, 32'h0);
      check(rd, 32'h0);
    end
    @(posedge clk);
    activity_decision <= 1'b1;
    noise_level <= `ABD_NOISE_GATE;
    run_frame(32'h10000000, 1'b0, 13, 3'h0);
    bus(1'b0, `ABD_REG_LT_LOW, 32'h0);
    check(rd, 32'h0);
    noise_level <= 16'h1F00;
    run_frame(32'h10000000, 1'b0, 13, 3'h0);
    bus(1'b0, `ABD_REG_LT_LOW, 32'h0);
    check(rd != 32'h0, 32'h1);
    $display("full path test done");
    for (i = 0; i < 6; i = i + 1) begin
      bus(1'b1, `ABD_REG_CTRL, {28'h0, row_ctrl[i]});
      bus(1'b1, `ABD_REG_BITRATE, {16'h0, row_rate[i]});
      bus(1'b0, `ABD_REG_CTRL, 32'h0);
      check(rd, {28'h0, row_ctrl[i]});
      run_frame(32'h01000000, i[0], 1, {1'b1, row_bw[i]});
      $display("row %0d done", i);
    end
    // a long loud run lifts every counter to the select level; 9.6 kbps caps full band
    bus(1'b1, `ABD_REG_CTRL, 32'h5);
    bus(1'b1, `ABD_REG_BITRATE, {16'h0, `ABD_RATE_9P6});
    for (i = 0; i < 87; i = i + 1) run_frame(32'h10000000, 1'b0, 13, 3'h0);
    run_frame(32'h10000000, 1'b0, 13, {1'b1, `ABD_BW_SWB});
    bus(1'b0, `ABD_REG_COUNTERS, 32'h0);
    check(rd, 32'h0B593264);
    // at full rate the full band result stands; forced counters stay saturated
    bus(1'b1, `ABD_REG_BITRATE, {16'h0, `ABD_RATE_128});
    run_frame(32'h10000000, 1'b0, 13, {1'b1, `ABD_BW_FB});
    bus(1'b0, `ABD_REG_COUNTERS, 32'h0);
    check(rd, 32'h0B793264);
    $display("selection and clamp test done");
    close_out;
  end
endmodule
